// ---- rtl/pcrd_pkg.sv ----
/*
 * Constants for the PHY clock and reset distribution block.
 * Assumes a single 50 MHz system clock; all derived clocks are
 * produced by dividers in that clock domain.
 */
package pcrd_pkg;
   localparam int unsigned CLK_PERIOD_NS = 20;
   // PLL lock time after global reset release
   localparam int unsigned PLL_LOCK_TIME_NS = 10000;
   localparam int unsigned PLL_LOCK_CYCLES =
      (PLL_LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Longest gap between reference clock edges before lock is lost
   localparam int unsigned REF_TIMEOUT_NS = 2000;
   localparam int unsigned REF_TIMEOUT_CYCLES = REF_TIMEOUT_NS / CLK_PERIOD_NS;
   // Half-rate clock cycles for which a soft reset holds the PHY
   localparam logic [3:0] SOFT_HOLD_HALF_CYCLES = 4'h2;
   // System clock cycles per half period of the scan clock
   localparam logic [3:0] SCAN_HALF_PERIOD = 4'h8;
   localparam int unsigned LOCK_CNT_W = 10;
   localparam int unsigned REF_CNT_W = 7;
   localparam int unsigned AC_WIDTH = 22;
   localparam int unsigned CLK_PAIRS = 1;
endpackage

// ---- rtl/pcrd_rst_sync.sv ----
/*
 * Reset synchroniser: asserts at once, releases on enable pulses.
 * Assumes arst_n is the global asynchronous reset and en marks the
 * rising edge of the target divided clock.
 */
`timescale 1ns/1ps
module pcrd_rst_sync (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic hold,
   input wire logic en,
   output logic rst_out_n
);
   logic stage_ff;
   logic out_ff;
   logic nxt_stage;
   logic nxt_out;

   always_comb begin
      nxt_stage = stage_ff;
      nxt_out = out_ff;
      if (hold) begin
         nxt_stage = 1'b0;
         nxt_out = 1'b0;
      end else if (en) begin
         nxt_stage = 1'b1;
         nxt_out = stage_ff;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         stage_ff <= 1'b0;
         out_ff <= 1'b0;
      end else begin
         stage_ff <= nxt_stage;
         out_ff <= nxt_out;
      end
   end

   assign rst_out_n = out_ff;
endmodule

// ---- rtl/pcrd_top.sv ----
/*
 * PHY clock and reset distribution: PLL lock model, derived clocks,
 * controller, memory and scan resets, memory clock pins, parity.
 * Assumes every input is synchronous to clk_sys; rst_n is the global reset.
 */
// Summary of operation
// - Active-low global reset clears the PLL model and all PHY logic.
// - Global reset is a level; system stays reset while it is low.
// - Soft reset edge resets the PHY only; the PLL keeps running.
// - Reset request output follows the PLL lock indication directly.
// - Half-rate clock output drives the controller and system logic.
// - Controller reset releases synchronously to the half-rate controller clock.
// - Half-rate configuration: auxiliary copy of the half-rate clock.
// - Full-rate configuration: auxiliary copy of the double-rate memory clock.
// - Low-frequency scan clock output for reconfiguration logic.
// - Scan reset drops asynchronously when global reset asserts.
// - Scan reset releases synchronously to the scan clock.
// - Memory clock pair driven out; pin input fed back for tracking.
// - Parity output and error flag only active for registered DIMMs.
// - Memory reset formed from global reset, soft reset and lock.
`timescale 1ns/1ps
module pcrd_top (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic pll_ref_clk,
   input wire logic soft_reset_n,
   input wire logic full_rate_mode,
   input wire logic registered_dimm,
   input wire logic [pcrd_pkg::AC_WIDTH-1:0] ac_bits,
   input wire logic mem_err_out_n,
   input wire logic [pcrd_pkg::CLK_PAIRS-1:0] mem_clk_in,
   input wire logic [pcrd_pkg::CLK_PAIRS-1:0] mem_clk_n_in,
   output logic [pcrd_pkg::CLK_PAIRS-1:0] mem_clk_out,
   output logic [pcrd_pkg::CLK_PAIRS-1:0] mem_clk_oe,
   output logic [pcrd_pkg::CLK_PAIRS-1:0] mem_clk_n_out,
   output logic [pcrd_pkg::CLK_PAIRS-1:0] mem_clk_n_oe,
   output logic vt_track_sample,
   output logic reset_request_n,
   output logic phy_half_rate_clock,
   output logic ctl_reset_n,
   output logic aux_half_rate_clk,
   output logic aux_full_rate_clk,
   output logic aux_scan_clk,
   output logic aux_scan_clk_reset_n,
   output logic mem_reset_n,
   output logic addr_cmd_parity_out,
   output logic parity_error_n
);
   localparam int unsigned LW = pcrd_pkg::LOCK_CNT_W;
   localparam int unsigned RW = pcrd_pkg::REF_CNT_W;

   // PLL model state
   logic ref_prev_ff, nxt_ref_prev;
   logic locked_ff, nxt_locked;
   logic [LW-1:0] lock_cnt_ff, nxt_lock_cnt;
   logic [RW-1:0] ref_cnt_ff, nxt_ref_cnt;
   logic ref_edge;

   assign ref_edge = pll_ref_clk & ~ref_prev_ff;

   always_comb begin
      nxt_ref_prev = pll_ref_clk;
      nxt_lock_cnt = lock_cnt_ff;
      nxt_ref_cnt = ref_edge ? '0 : ref_cnt_ff + RW'(1);
      nxt_locked = locked_ff;
      if (ref_cnt_ff == RW'(pcrd_pkg::REF_TIMEOUT_CYCLES)) begin
         // Reference stalled: lock is lost and relock starts over
         // A returning edge must leave this state, or relock never begins
         nxt_ref_cnt = ref_edge ? '0 : ref_cnt_ff;
         nxt_lock_cnt = '0;
         nxt_locked = 1'b0;
      end else if (lock_cnt_ff == LW'(pcrd_pkg::PLL_LOCK_CYCLES)) begin
         nxt_locked = 1'b1;
      end else begin
         nxt_lock_cnt = lock_cnt_ff + LW'(1);
      end
   end

   // PLL cleared only by global reset, never by soft reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ref_prev_ff <= 1'b0;
         locked_ff <= 1'b0;
         lock_cnt_ff <= '0;
         ref_cnt_ff <= '0;
      end else begin
         ref_prev_ff <= nxt_ref_prev;
         locked_ff <= nxt_locked;
         lock_cnt_ff <= nxt_lock_cnt;
         ref_cnt_ff <= nxt_ref_cnt;
      end
   end

   // Derived clocks; they stop while the PLL is unlocked
   logic [1:0] div_ff, nxt_div;
   logic [3:0] scan_cnt_ff, nxt_scan_cnt;
   logic scan_ff, nxt_scan;
   logic half_rise_en, scan_rise_en;

   assign half_rise_en = locked_ff & (div_ff == 2'h1);
   assign scan_rise_en = locked_ff & ~scan_ff & (scan_cnt_ff == pcrd_pkg::SCAN_HALF_PERIOD - 4'h1);

   always_comb begin
      nxt_div = div_ff;
      nxt_scan_cnt = scan_cnt_ff;
      nxt_scan = scan_ff;
      if (locked_ff) begin
         nxt_div = div_ff + 2'h1;
         nxt_scan_cnt = scan_cnt_ff + 4'h1;
         if (scan_cnt_ff == pcrd_pkg::SCAN_HALF_PERIOD - 4'h1) begin
            nxt_scan_cnt = 4'h0;
            nxt_scan = ~scan_ff;
         end
      end
   end

   // Soft reset edge detect and PHY reset hold
   logic soft_prev_ff, nxt_soft_prev;
   logic [3:0] hold_cnt_ff, nxt_hold_cnt;
   logic soft_fall, phy_hold;

   assign soft_fall = soft_prev_ff & ~soft_reset_n;
   assign phy_hold = (hold_cnt_ff != 4'h0) | ~locked_ff;

   always_comb begin
      nxt_soft_prev = soft_reset_n;
      nxt_hold_cnt = hold_cnt_ff;
      if (soft_fall) begin
         nxt_hold_cnt = pcrd_pkg::SOFT_HOLD_HALF_CYCLES;
      end else if (half_rise_en && hold_cnt_ff != 4'h0) begin
         nxt_hold_cnt = hold_cnt_ff - 4'h1; // Counts half-rate rising edges; the first counted cycle can be partial
      end
   end

   // Parity and pin state
   logic parity_ff, nxt_parity;
   logic perr_n_ff, nxt_perr_n;
   logic vt_ff, nxt_vt;
   logic memrst_ff, nxt_memrst;
   logic fr_ff, nxt_fr, hr_ff, nxt_hr, aux_h_ff, nxt_aux_h, aux_f_ff, nxt_aux_f;
   logic frn_ff, nxt_frn;

   always_comb begin
      nxt_fr = locked_ff & ~div_ff[0];
      nxt_frn = ~nxt_fr;
      nxt_hr = locked_ff & ~div_ff[1];
      nxt_aux_h = ~full_rate_mode & nxt_hr;
      nxt_aux_f = full_rate_mode & nxt_fr;
      nxt_parity = registered_dimm & (^ac_bits);
      nxt_perr_n = perr_n_ff;
      if (phy_hold) begin
         nxt_perr_n = 1'b1; // Error flag stands until the PHY is reset
      end else if (registered_dimm && !mem_err_out_n) begin
         nxt_perr_n = 1'b0;
      end
      // Both legs of the pair must agree for a valid sample
      nxt_vt = (half_rise_en & ~phy_hold) ? (mem_clk_in[0] & ~mem_clk_n_in[0]) : vt_ff;
      nxt_memrst = ~phy_hold;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         div_ff <= 2'h0;
         scan_cnt_ff <= 4'h0;
         scan_ff <= 1'b0;
         soft_prev_ff <= 1'b1;
         hold_cnt_ff <= 4'h0;
         parity_ff <= 1'b0;
         perr_n_ff <= 1'b1;
         vt_ff <= 1'b0;
         memrst_ff <= 1'b0;
         fr_ff <= 1'b0;
         frn_ff <= 1'b1;
         hr_ff <= 1'b0;
         aux_h_ff <= 1'b0;
         aux_f_ff <= 1'b0;
      end else begin
         div_ff <= nxt_div;
         scan_cnt_ff <= nxt_scan_cnt;
         scan_ff <= nxt_scan;
         soft_prev_ff <= nxt_soft_prev;
         hold_cnt_ff <= nxt_hold_cnt;
         parity_ff <= nxt_parity;
         perr_n_ff <= nxt_perr_n;
         vt_ff <= nxt_vt;
         memrst_ff <= nxt_memrst;
         fr_ff <= nxt_fr;
         frn_ff <= nxt_frn;
         hr_ff <= nxt_hr;
         aux_h_ff <= nxt_aux_h;
         aux_f_ff <= nxt_aux_f;
      end
   end

   // Controller reset released on half-rate edges
   pcrd_rst_sync u_ctl_sync (
      .clk_sys(clk_sys),
      .arst_n(rst_n),
      .hold(phy_hold),
      .en(half_rise_en),
      .rst_out_n(ctl_reset_n)
   );

   // Scan reset: async drop on global reset, release on scan edges
   pcrd_rst_sync u_scan_sync (
      .clk_sys(clk_sys),
      .arst_n(rst_n),
      .hold(1'b0),
      .en(scan_rise_en),
      .rst_out_n(aux_scan_clk_reset_n)
   );

   assign reset_request_n = locked_ff;
   assign phy_half_rate_clock = hr_ff;
   assign aux_half_rate_clk = aux_h_ff;
   assign aux_full_rate_clk = aux_f_ff;
   assign aux_scan_clk = scan_ff;
   assign mem_reset_n = memrst_ff;
   assign addr_cmd_parity_out = parity_ff;
   assign parity_error_n = perr_n_ff;
   assign vt_track_sample = vt_ff;
   // Clock pair always driven; mem_clk_out sits low and mem_clk_n_out high while the PLL is unlocked
   assign mem_clk_out = {pcrd_pkg::CLK_PAIRS{fr_ff}};
   assign mem_clk_n_out = {pcrd_pkg::CLK_PAIRS{frn_ff}};
   assign mem_clk_oe = {pcrd_pkg::CLK_PAIRS{1'b1}};
   assign mem_clk_n_oe = {pcrd_pkg::CLK_PAIRS{1'b1}};
endmodule

// ---- sim/pcrd_sys_model.sv ----
/* Far side: reference clock source and system reset controller. Shares clk_sys. */
`timescale 1ns/1ps
module pcrd_sys_model (
   input wire logic clk_sys,
   input wire logic ref_stall,
   input wire logic sys_rst_n,
   input wire logic reset_request_n,
   output logic pll_ref_clk,
   output logic glob_rst_n,
   output int unsigned req_count
);
   logic req_ff = 1'b0;
   logic fb_ff = 1'b1;
   // Request edge gated with the system reset and fed back as global reset
   assign glob_rst_n = sys_rst_n & fb_ff;
   initial pll_ref_clk = 1'b0;
   initial req_count = 0;
   // Stall freezes the reference so lock is really lost
   always @(posedge clk_sys) begin
      pll_ref_clk <= ref_stall ? pll_ref_clk : !pll_ref_clk;
      req_ff <= reset_request_n;
      // Edge, not level: the request stays low all through locking
      if (req_ff && !reset_request_n) req_count <= req_count + 1;
      fb_ff <= !(req_ff && !reset_request_n);
   end
endmodule

// ---- sim/pcrd_top_checker.sv ----
/* Port assertions for pcrd_top. Bound to every pcrd_top instance below. */
`timescale 1ns/1ps
module pcrd_top_checker (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic soft_reset_n,
   input wire logic full_rate_mode,
   input wire logic registered_dimm,
   input wire logic mem_err_out_n,
   input wire logic reset_request_n,
   input wire logic phy_half_rate_clock,
   input wire logic ctl_reset_n,
   input wire logic aux_half_rate_clk,
   input wire logic aux_full_rate_clk,
   input wire logic aux_scan_clk,
   input wire logic aux_scan_clk_reset_n,
   input wire logic mem_reset_n,
   input wire logic parity_error_n
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence soft_edge;
      $fell(soft_reset_n) && reset_request_n;
   endsequence
   sequence phy_held;
      !ctl_reset_n && !mem_reset_n;
   endsequence
   scan_async_a: assert property ($rose(rst_n) |-> !aux_scan_clk_reset_n)
      else $error("scan reset high at release");
   loss_ctl_a: assert property ($fell(reset_request_n) |-> ##[0:3] !ctl_reset_n)
      else $error("ctl reset missed lock loss");
   ctl_release_a: assert property ($rose(reset_request_n) |-> !ctl_reset_n ##[1:12] ctl_reset_n)
      else $error("ctl reset release wrong");
   soft_hold_a: assert property (soft_edge |-> ##[2:3] phy_held)
      else $error("soft reset did not hold phy");
   pll_kept_a: assert property (soft_edge |-> reset_request_n [*8])
      else $error("soft reset disturbed lock");
   scan_kept_a: assert property ($fell(soft_reset_n) && aux_scan_clk_reset_n
      |-> aux_scan_clk_reset_n [*8])
      else $error("soft reset hit scan reset");
   scan_sync_a: assert property ($rose(aux_scan_clk_reset_n) |-> aux_scan_clk)
      else $error("scan reset release off scan clock");
   aux_mode_a: assert property ($stable(full_rate_mode)
      |-> (full_rate_mode ? !aux_half_rate_clk : !aux_full_rate_clk))
      else $error("wrong auxiliary clock active");
   aux_copy_a: assert property ($stable(full_rate_mode) && !full_rate_mode
      |-> aux_half_rate_clk == phy_half_rate_clock)
      else $error("half rate copy differs");
   par_err_a: assert property (registered_dimm && !mem_err_out_n && ctl_reset_n && mem_reset_n
      |-> ##[1:2] !parity_error_n)
      else $error("parity error not flagged");
endmodule
bind pcrd_top pcrd_top_checker u_chk (.clk_sys, .rst_n, .soft_reset_n, .full_rate_mode,
   .registered_dimm, .mem_err_out_n, .reset_request_n, .phy_half_rate_clock, .ctl_reset_n,
   .aux_half_rate_clk, .aux_full_rate_clk, .aux_scan_clk, .aux_scan_clk_reset_n,
   .mem_reset_n, .parity_error_n);

// ---- sim/phy_clock_reset_distribution_tb.sv ----
/* Self-checking bench for pcrd_top. Needs pcrd_pkg, pcrd_sys_model and the checker. */
`timescale 1ns/1ps
module phy_clock_reset_distribution_tb;
   logic clk_sys = 1'h0, rst_n = 1'h0, soft_reset_n = 1'h1, full_rate_mode = 1'h0;
   logic registered_dimm = 1'h0, mem_err_out_n = 1'h1, ref_stall = 1'h0;
   logic [pcrd_pkg::AC_WIDTH-1:0] ac_bits = 22'h000007;
   logic [pcrd_pkg::CLK_PAIRS-1:0] mem_clk_out, mem_clk_n_out, mem_clk_oe, mem_clk_n_oe;
   logic glob_rst_n, vt_track_sample;
   logic pll_ref_clk, reset_request_n, phy_half_rate_clock, ctl_reset_n, aux_half_rate_clk;
   logic aux_full_rate_clk, aux_scan_clk, aux_scan_clk_reset_n, mem_reset_n;
   logic addr_cmd_parity_out, parity_error_n;
   int unsigned req_count;
   int bad_count = 0, check_count = 0;
   always #10 clk_sys = !clk_sys;
   pcrd_sys_model far (.clk_sys, .ref_stall, .sys_rst_n(rst_n), .reset_request_n,
      .pll_ref_clk, .glob_rst_n, .req_count);
   // Pin input path looped back from the driven clock pair
   pcrd_top dut (.clk_sys, .rst_n(glob_rst_n), .pll_ref_clk, .soft_reset_n, .full_rate_mode,
      .registered_dimm, .ac_bits, .mem_err_out_n, .mem_clk_in(mem_clk_out),
      .mem_clk_n_in(mem_clk_n_out), .mem_clk_out, .mem_clk_oe, .mem_clk_n_out,
      .mem_clk_n_oe, .vt_track_sample, .reset_request_n, .phy_half_rate_clock,
      .ctl_reset_n, .aux_half_rate_clk, .aux_full_rate_clk, .aux_scan_clk,
      .aux_scan_clk_reset_n, .mem_reset_n, .addr_cmd_parity_out, .parity_error_n);
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s exp %0h got %0h", nm, exp, got);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task wait_lock;
      int n;
      for (n = 0; n < 700 && reset_request_n !== 1'h1; n++) tick(1);
      chk("lock time", 1, n >= 480 && n <= 520);
      for (n = 0; n < 30 && ctl_reset_n !== 1'h1; n++) tick(1);
      chk("ctl_reset_n", 1, ctl_reset_n);
      chk("mem_reset_n", 1, mem_reset_n);
   endtask
   task t_global;
      @(posedge clk_sys) rst_n <= 1'h0;
      #1 chk("scan rst async", 0, aux_scan_clk_reset_n);
      tick(10);
      chk("hold ctl", 0, ctl_reset_n);
      chk("hold req", 0, reset_request_n);
      chk("hold perr", 1, parity_error_n);
      chk("hold vt", 0, vt_track_sample);
      @(posedge clk_sys) rst_n <= 1'h1;
      wait_lock();
      $display("t_global done");
   endtask
   task t_clocks(input logic mode);
      int h, a, f, m, s;
      logic ph, pa, pf, pm, ps;
      @(posedge clk_sys) full_rate_mode <= mode;
      tick(40);
      {h, a, f, m, s} = '0;
      {ph, pa, pf, pm, ps} = {phy_half_rate_clock, aux_half_rate_clk, aux_full_rate_clk,
         mem_clk_out[0], aux_scan_clk};
      repeat (48) begin
         tick(1);
         h += phy_half_rate_clock & !ph;
         a += aux_half_rate_clk & !pa;
         f += aux_full_rate_clk & !pf;
         m += mem_clk_out[0] & !pm;
         s += aux_scan_clk & !ps;
         {ph, pa, pf, pm, ps} = {phy_half_rate_clock, aux_half_rate_clk, aux_full_rate_clk,
            mem_clk_out[0], aux_scan_clk};
      end
      chk("half clk", 12, h);
      chk("aux half", mode ? 0 : 12, a);
      chk("aux full", mode ? 24 : 0, f);
      chk("mem clk", 24, m);
      chk("mem clk pair", 1, mem_clk_out ^ mem_clk_n_out);
      chk("mem clk oe", 2'h3, {mem_clk_oe, mem_clk_n_oe});
      chk("vt sample", 1, vt_track_sample);
      chk("scan clk", 3, s);
      $display("t_clocks done");
   endtask
   task t_parity;
      chk("no parity", 0, addr_cmd_parity_out);
      @(posedge clk_sys) registered_dimm <= 1'h1;
      tick(3);
      chk("parity odd", 1, addr_cmd_parity_out);
      @(posedge clk_sys) ac_bits <= 22'h200001;
      tick(3);
      chk("parity even", 0, addr_cmd_parity_out);
      @(posedge clk_sys) mem_err_out_n <= 1'h0;
      @(posedge clk_sys) mem_err_out_n <= 1'h1;
      tick(20);
      chk("perr sticky", 0, parity_error_n);
      $display("t_parity done");
   endtask
   task t_soft;
      int n;
      @(posedge clk_sys) soft_reset_n <= 1'h0;
      tick(4);
      chk("soft ctl", 0, ctl_reset_n);
      chk("soft mem", 0, mem_reset_n);
      chk("soft pll", 1, reset_request_n);
      chk("soft scan", 1, aux_scan_clk_reset_n);
      @(posedge clk_sys) soft_reset_n <= 1'h1;
      for (n = 0; n < 40 && ctl_reset_n !== 1'h1; n++) tick(1);
      chk("soft end", 1, ctl_reset_n);
      chk("perr clear", 1, parity_error_n);
      $display("t_soft done");
   endtask
   task t_loss;
      int unsigned r;
      r = req_count;
      @(posedge clk_sys) ref_stall <= 1'h1;
      // Fed-back reset restarts the lock count; stall past a second timeout
      tick(230);
      chk("loss req", 0, reset_request_n);
      chk("fb scan rst", 0, aux_scan_clk_reset_n);
      chk("loss ctl", 0, ctl_reset_n);
      chk("req edges", r + 1, req_count);
      @(posedge clk_sys) ref_stall <= 1'h0;
      wait_lock();
      $display("t_loss done");
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Whole run is about 2000 cycles
   initial begin
      #(20 * 8000);
      bad_count++;
      test_done();
   end
   initial begin
      tick(10);
      @(posedge clk_sys) rst_n <= 1'h1;
      wait_lock();
      t_clocks(1'h1);
      t_clocks(1'h0);
      t_parity();
      t_soft();
      t_loss();
      t_global();
      test_done();
   end
endmodule
